// file: hdl/bmshp_top.sv
// Behaviour
// - Standalone command: rw, page, address, data
// - Chain command adds address and check code
// - Decode against pages one to five
// - Output pin driven only while selected
// - First bit fixes transaction byte count
// - Long deselect resets counters and state
// - Read data buffered, shifted out falling edges
// - Reads two bytes, writes three, replies two
// - Pending reply leaves during write bytes
// - Half duplex: pending low when byte buffered
// - Deselect releases pending, repeat per byte
// - Input ignored while transmitting in chain
// - Four byte reply buffer toward host
// - Pending never asserted while host selects
// - Measure code versus read, action, write
// - No check code in standalone mode
// - No reply to writes; unknown read zero
// - Incomplete command dropped as unrecognized
// - Reset command resets device; others plain
// - Fault output low until status cleared
// - Role pins select standalone or chain role
// - Most significant bit first on wire
`timescale 1ns/1ps
module bmshp_top (
   // Reference clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Serial port pins
   input wire logic spiClk,
   input wire logic hostCsN,
   input wire logic hostDin,
   output logic hostDout,
   output logic hostDoutOe,
   output logic dataReadyN,
   // Link role pins
   input wire logic link_role_sel_a,
   input wire logic link_role_sel_b,
   // Decoded commands and read answers
   output bmshp_pkg::bmshp_cmd_t cmdOut,
   output logic cmdValid,
   output logic devResetReq,
   input wire bmshp_pkg::bmshp_rsp_t rdRsp,
   input wire logic rdRspValid,
   // Chain side byte streams
   output logic [bmshp_pkg::BYTE_W-1:0] fwdByte,
   output logic fwdValid,
   input wire logic [bmshp_pkg::BYTE_W-1:0] chainByte,
   input wire logic chainValid,
   output logic rspOverflow,
   // Fault status
   input wire logic [bmshp_pkg::DATA_W-1:0] faultEvent,
   input wire logic [bmshp_pkg::DATA_W-1:0] faultDataActive,
   output logic faultN
);
   import bmshp_pkg::*;

   logic [BIT_CNT_W-1:0] rxCnt_reg;
   logic rxAny_reg;
   logic rxTgl_reg;
   logic [BYTE_W-1:0] rxShift_reg;
   logic [2:0] txCnt_reg;
   logic [BYTE_W-1:0] txHold_reg;
   logic oeAllow_reg;

   // Link clock domain: the counter restarts with every select
   // MSB first in
   always_ff @(posedge spiClk or posedge hostCsN) begin
      if (hostCsN) begin
         rxCnt_reg <= '0;
         rxAny_reg <= 1'b0;
      end else if (rxCnt_reg != BITS_PER_BYTE) begin
         rxCnt_reg <= rxCnt_reg + 4'h1;
         rxAny_reg <= 1'b1;
      end
   end

   always_ff @(posedge spiClk) begin
      if (rxCnt_reg != BITS_PER_BYTE) begin
         rxShift_reg <= {rxShift_reg[BYTE_W-2:0], hostDin};
      end
   end

   // Toggle survives deselect, so a byte closed just before cs rises is not lost
   always_ff @(posedge spiClk or negedge reset_n) begin
      if (!reset_n) begin
         rxTgl_reg <= 1'b0;
      end else if (rxCnt_reg == BITS_PER_BYTE - 4'h1) begin
         rxTgl_reg <= ~rxTgl_reg;
      end
   end

   always_ff @(negedge spiClk or posedge hostCsN) begin
      if (hostCsN) begin
         txCnt_reg <= 3'h0;
      end else begin
         txCnt_reg <= txCnt_reg + 3'h1;
      end
   end

   always_comb begin
      hostDout = txHold_reg[3'h7 - txCnt_reg];
   end

   assign hostDoutOe = ~hostCsN & oeAllow_reg;

   // Reference domain synchronisers
   logic csMeta_reg, csSync_reg, csPrev_reg;
   logic anyMeta_reg, anySync_reg;
   logic tglMeta_reg, tglSync_reg, tglPrev_reg;
   logic [1:0] roleMeta_reg, role_reg;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         csMeta_reg <= 1'b1;
         csSync_reg <= 1'b1;
         csPrev_reg <= 1'b1;
         anyMeta_reg <= 1'b0;
         anySync_reg <= 1'b0;
         tglMeta_reg <= 1'b0;
         tglSync_reg <= 1'b0;
         tglPrev_reg <= 1'b0;
         roleMeta_reg <= ROLE_STANDALONE;
         role_reg <= ROLE_STANDALONE;
      end else begin
         csMeta_reg <= hostCsN;
         csSync_reg <= csMeta_reg;
         csPrev_reg <= csSync_reg;
         anyMeta_reg <= rxAny_reg;
         anySync_reg <= anyMeta_reg;
         tglMeta_reg <= rxTgl_reg;
         tglSync_reg <= tglMeta_reg;
         tglPrev_reg <= tglSync_reg;
         roleMeta_reg <= {link_role_sel_a, link_role_sel_b};
         role_reg <= roleMeta_reg;
      end
   end

   logic csFall, csRise, byteEvt, standalone, chainMaster;
   assign csFall = csPrev_reg & ~csSync_reg;
   assign csRise = ~csPrev_reg & csSync_reg;
   assign byteEvt = tglSync_reg ^ tglPrev_reg;
   assign standalone = (role_reg == ROLE_STANDALONE);
   assign chainMaster = (role_reg == ROLE_CHAIN_MASTER);

   // Per-block bookkeeping
   logic hadBits_reg, gotByte_reg, txMode_reg, presented_reg;
   logic [BUF_CNT_W-1:0] rspCount_reg;
   logic dataReadyN_reg;
   logic incomplete, timeoutEvt, abortCmd;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         hadBits_reg <= 1'b0;
         gotByte_reg <= 1'b0;
         txMode_reg <= 1'b0;
         presented_reg <= 1'b0;
      end else if (csFall) begin
         hadBits_reg <= 1'b0;
         gotByte_reg <= 1'b0;
         txMode_reg <= chainMaster & ~dataReadyN_reg;
         presented_reg <= (rspCount_reg != '0);
      end else begin
         if (anySync_reg) begin
            hadBits_reg <= 1'b1;
         end
         if (byteEvt) begin
            gotByte_reg <= 1'b1;
         end
      end
   end

   assign incomplete = csRise & hadBits_reg & ~gotByte_reg & ~byteEvt;

   logic [IDLE_CNT_W-1:0] idleCnt_reg;
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !csSync_reg) begin
         idleCnt_reg <= '0;
      end else if (idleCnt_reg != CS_IDLE_LIMIT + 12'h001) begin
         idleCnt_reg <= idleCnt_reg + 12'h001;
      end
   end
   assign timeoutEvt = csSync_reg & (idleCnt_reg == CS_IDLE_LIMIT);
   assign abortCmd = timeoutEvt | incomplete;

   // Command framing
   bmshp_state_t frameState;
   logic [BYTE_W-1:0] firstByte_reg, secondByte_reg;
   logic [2:0] pageSel;
   logic [5:0] addrSel;
   logic pageOk;

   always_ff @(posedge ref_clk) begin
      if (!reset_n || abortCmd || !standalone) begin
         frameState <= ST_IDLE;
      end else if (byteEvt) begin
         case (frameState)
            ST_IDLE: frameState <= ST_GOT1;
            ST_GOT1: frameState <= firstByte_reg[RW_BIT] ? ST_GOT2W : ST_IDLE;
            ST_GOT2W: frameState <= ST_IDLE;
            default: frameState <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         firstByte_reg <= '0;
         secondByte_reg <= '0;
      end else if (byteEvt && frameState == ST_IDLE) begin
         firstByte_reg <= rxShift_reg;
      end else if (byteEvt && frameState == ST_GOT1) begin
         secondByte_reg <= rxShift_reg;
      end
   end

   always_comb begin
      pageSel = firstByte_reg[PAGE_MSB:PAGE_LSB];
      if (frameState == ST_GOT1) begin
         addrSel = {firstByte_reg[ADDR_HI_MSB:0], rxShift_reg[7:6]};
      end else begin
         addrSel = {firstByte_reg[ADDR_HI_MSB:0], secondByte_reg[7:6]};
      end
      pageOk = (pageSel >= PAGE_FIRST) && (pageSel <= PAGE_LAST);
   end

   logic readDone, writeDone, faultWr, pendingRead_reg, zeroRead_reg;
   logic [DATA_W-1:0] writeData;
   assign readDone = standalone & byteEvt & (frameState == ST_GOT1) & ~firstByte_reg[RW_BIT];
   assign writeDone = standalone & byteEvt & (frameState == ST_GOT2W);
   assign writeData = {secondByte_reg[5:0], rxShift_reg};
   assign faultWr = writeDone & (pageSel == FAULT_STATUS_PAGE) &
      (addrSel == FAULT_STATUS_ADDR);

   logic pushTwo;
   logic [15:0] rspWord;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cmdOut <= '0;
         cmdValid <= 1'b0;
         devResetReq <= 1'b0;
         pendingRead_reg <= 1'b0;
         zeroRead_reg <= 1'b0;
      end else begin
         cmdValid <= 1'b0;
         devResetReq <= 1'b0;
         if (pushTwo) begin
            pendingRead_reg <= 1'b0;
         end
         if (readDone) begin
            cmdOut.page <= pageSel;
            cmdOut.addr <= addrSel;
            cmdOut.data <= {8'h00, rxShift_reg[5:0]};
            if (!pageOk) begin
               pendingRead_reg <= 1'b1;
               zeroRead_reg <= 1'b1;
            end else if (pageSel == PAGE_ACTION) begin
               cmdOut.kind <= (addrSel == ADDR_MEASURE) ? KIND_MEASURE : KIND_ACTION;
               cmdValid <= 1'b1;
               devResetReq <= (addrSel == ADDR_RESET);
            end else begin
               cmdOut.kind <= KIND_READ;
               cmdValid <= 1'b1;
               pendingRead_reg <= 1'b1;
               zeroRead_reg <= 1'b0;
            end
         end else if (writeDone && pageOk) begin
            cmdOut.kind <= KIND_WRITE;
            cmdOut.page <= pageSel;
            cmdOut.addr <= addrSel;
            cmdOut.data <= writeData;
            cmdValid <= 1'b1;
         end
      end
   end

   logic [DATA_W-1:0] faultStatus_reg, faultStatusNext, faultClr;
   always_comb begin
      faultClr = faultWr ? (~writeData & ~faultDataActive) : '0;
      faultStatusNext = (faultStatus_reg & ~faultClr) | faultEvent;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         faultStatus_reg <= FAULT_STATUS_RST;
         faultN <= 1'b1;
      end else begin
         faultStatus_reg <= faultStatusNext;
         faultN <= (faultStatusNext == '0);
      end
   end

   // Reply buffer
   logic [BYTE_W-1:0] rspBuf [0:BUF_DEPTH-1];
   logic [BUF_PTR_W-1:0] wrPtr_reg, rdPtr_reg;
   logic pushOne, popByte;
   logic [BUF_CNT_W-1:0] freeSlots, pushAcc;

   assign pushTwo = standalone & pendingRead_reg & (zeroRead_reg | rdRspValid);
   assign rspWord = (zeroRead_reg || !rdRsp.hit) ? 16'h0000 : {2'b00, rdRsp.data};
   assign pushOne = chainMaster & chainValid;
   assign popByte = csRise & (gotByte_reg | byteEvt) &
      (standalone ? presented_reg : txMode_reg);

   always_comb begin
      freeSlots = BUF_CNT_W'(BUF_DEPTH) - rspCount_reg + {2'b00, popByte};
      pushAcc = '0;
      if (pushTwo && freeSlots >= 3'h2) begin
         pushAcc = 3'h2;
      end else if (pushOne && freeSlots >= 3'h1) begin
         pushAcc = 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         rspCount_reg <= '0;
         rspOverflow <= 1'b0;
      end else begin
         wrPtr_reg <= wrPtr_reg + pushAcc[BUF_PTR_W-1:0];
         rdPtr_reg <= rdPtr_reg + {1'b0, popByte};
         rspCount_reg <= rspCount_reg + pushAcc - {2'b00, popByte};
         rspOverflow <= (pushTwo | pushOne) & (pushAcc == '0);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (pushAcc == 3'h2) begin
         rspBuf[wrPtr_reg] <= rspWord[15:8];
         rspBuf[wrPtr_reg + 2'h1] <= rspWord[7:0];
      end else if (pushAcc == 3'h1) begin
         rspBuf[wrPtr_reg] <= chainByte;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         txHold_reg <= '0;
      end else if (csSync_reg) begin
         txHold_reg <= (rspCount_reg != '0) ? rspBuf[rdPtr_reg] : 8'h00;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n || !chainMaster) begin
         dataReadyN_reg <= 1'b1;
      end else if (!dataReadyN_reg) begin
         dataReadyN_reg <= csRise;
      end else begin
         dataReadyN_reg <= ~(csSync_reg & csPrev_reg & (rspCount_reg != '0));
      end
   end
   assign dataReadyN = dataReadyN_reg;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         oeAllow_reg <= 1'b0;
      end else begin
         oeAllow_reg <= standalone | (chainMaster & ~dataReadyN_reg);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         fwdByte <= '0;
         fwdValid <= 1'b0;
      end else begin
         fwdValid <= chainMaster & byteEvt & ~txMode_reg;
         if (byteEvt) begin
            fwdByte <= rxShift_reg;
         end
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   a_dout_oe_window: assert property (
      hostDoutOe |-> (!hostCsN && (standalone || !dataReadyN_reg)))
      else $error("serial output driven while deselected");
   a_idle_timeout: assert property (
      (csSync_reg && idleCnt_reg == CS_IDLE_LIMIT) |=> (frameState == ST_IDLE))
      else $error("timeout did not return framing to idle");
   a_incomplete_drop: assert property (incomplete |=> (frameState == ST_IDLE))
      else $error("incomplete command not dropped");
   a_write_third_byte: assert property (
      (standalone && byteEvt && frameState == ST_GOT1 && firstByte_reg[RW_BIT] && !abortCmd)
      |=> (frameState == ST_GOT2W))
      else $error("write did not wait for third byte");
   a_measure_kind: assert property (
      (cmdValid && cmdOut.page == PAGE_ACTION && cmdOut.addr == ADDR_MEASURE)
      |-> (cmdOut.kind == KIND_MEASURE))
      else $error("measure code decoded wrongly");
   a_unknown_zero: assert property (
      (readDone && !pageOk) |-> ##[1:3] (pushTwo && rspWord == 16'h0000))
      else $error("unknown read did not reply zero");
   a_ready_release: assert property ((csRise && !dataReadyN_reg) |=> dataReadyN_reg)
      else $error("pending line not released on deselect");
   a_ready_no_select: assert property ($fell(dataReadyN_reg) |-> $past(csSync_reg))
      else $error("pending asserted while selected");
   a_tx_ignores_rx: assert property ((chainMaster && byteEvt && txMode_reg) |=> !fwdValid)
      else $error("input forwarded during transmit");
   a_fault_hold: assert property ((|faultEvent) |=> (!faultN && faultStatus_reg != '0))
      else $error("fault output not low after event");
   a_buf_bound: assert property (
      (rspCount_reg == BUF_CNT_W'(BUF_DEPTH) && pushOne && !popByte) |=> rspOverflow)
      else $error("full buffer accepted a byte");

   c_write_cmd: cover property (cmdValid && cmdOut.kind == KIND_WRITE);
   c_read_reply: cover property (pushTwo && !zeroRead_reg);
   c_chain_ready: cover property (!dataReadyN_reg ##[1:200] csRise);
   c_timeout: cover property (timeoutEvt && frameState != ST_IDLE);

endmodule : bmshp_top

// file: hdl/bmshp_pkg.sv
package bmshp_pkg;

   // Reference clock and chip-select idle timeout
   localparam int REF_CLK_HZ = 40_000_000;
   localparam int CS_IDLE_TIMEOUT_NS = 100_000;
   localparam int CS_IDLE_TIMEOUT_CYC =
      int'((64'(CS_IDLE_TIMEOUT_NS) * 64'(REF_CLK_HZ)) / 64'd1_000_000_000);
   localparam int IDLE_CNT_W = 12;
   localparam logic [IDLE_CNT_W-1:0] CS_IDLE_LIMIT = IDLE_CNT_W'(CS_IDLE_TIMEOUT_CYC - 1);

   // Widths and response buffer shape
   localparam int BYTE_W = 8;
   localparam int DATA_W = 14;
   localparam int BIT_CNT_W = 4;
   localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
   localparam int BUF_DEPTH = 4;
   localparam int BUF_PTR_W = 2;
   localparam int BUF_CNT_W = 3;

   // Link role pin codes {sel_a, sel_b}
   localparam logic [1:0] ROLE_STANDALONE = 2'b00;
   localparam logic [1:0] ROLE_CHAIN_MASTER = 2'b01;

   // Field positions in the first command byte
   localparam int RW_BIT = 7;
   localparam int PAGE_MSB = 6;
   localparam int PAGE_LSB = 4;
   localparam int ADDR_HI_MSB = 3;

   // Pages and special addresses
   localparam logic [2:0] PAGE_FIRST = 3'h1;
   localparam logic [2:0] PAGE_LAST = 3'h5;
   localparam logic [2:0] PAGE_ACTION = 3'h3;
   localparam logic [5:0] ADDR_MEASURE = 6'h08;
   localparam logic [5:0] ADDR_RESET = 6'h3e;
   localparam logic [2:0] FAULT_STATUS_PAGE = 3'h2;
   localparam logic [5:0] FAULT_STATUS_ADDR = 6'h30;
   localparam logic [DATA_W-1:0] FAULT_STATUS_RST = 14'h0000;

   typedef enum logic [1:0] {
      KIND_READ = 2'b00,
      KIND_WRITE = 2'b01,
      KIND_MEASURE = 2'b10,
      KIND_ACTION = 2'b11
   } bmshp_kind_t;

   typedef struct packed {
      bmshp_kind_t kind;
      logic [2:0] page;
      logic [5:0] addr;
      logic [DATA_W-1:0] data;
   } bmshp_cmd_t;

   typedef struct packed {
      logic hit;
      logic [DATA_W-1:0] data;
   } bmshp_rsp_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_GOT1 = 2'b01,
      ST_GOT2W = 2'b10
   } bmshp_state_t;

endpackage : bmshp_pkg

// file: bench/bmshp_host_model.sv
`timescale 1ns/1ps
module bmshp_host_model (
   // Serial pins toward the port
   output logic spiClk,
   output logic hostCsN,
   output logic hostDin,
   input wire logic hostDout,
   input wire logic hostDoutOe
);
   initial begin
      spiClk = 1'b0;
      hostCsN = 1'b1;
      hostDin = 1'b0;
   end

   // Clock only inside frames; nBits below 8 cuts a byte short
   // one byte per select, MSB first
   task automatic xfer(input logic [7:0] tx, input int nBits, output logic [7:0] rx,
      output logic oeAll);
      rx = 8'h00;
      oeAll = 1'b1;
      #7 hostCsN = 1'b0;
      #150;
      for (int i = 0; i < nBits; i++) begin
         hostDin = tx[7-i];
         #62.5 spiClk = 1'b1;
         rx = {rx[6:0], hostDout};
         oeAll = oeAll & hostDoutOe;
         #62.5 spiClk = 1'b0;
      end
      #62.5 hostCsN = 1'b1;
      // Released line must not keep a stale level
      hostDin = ~hostDin;
      #400;
   endtask : xfer
endmodule : bmshp_host_model

// file: bench/testbench.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin failCount++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
   import bmshp_pkg::*;
   logic ref_clk, reset_n, spiClk, hostCsN, hostDin, hostDout, hostDoutOe, dataReadyN;
   logic roleSelA, roleSelB, cmdValid, devResetReq, fwdValid, chainValid, rspOverflow;
   logic faultN, oeAll, prevRdy;
   logic rdRspValid = 1'b0;
   bmshp_cmd_t cmdOut, lastCmd;
   bmshp_rsp_t rdRsp;
   logic [7:0] fwdByte, chainByte, lastFwd;
   logic [13:0] faultEvent, faultDataActive;
   int failCount = 0;
   int comparisons = 0;
   int nCmd = 0;
   int nRst = 0;
   int nFwd = 0;
   int nOvf = 0;
   int nRise = 0;

   bmshp_top i_dut (.ref_clk, .reset_n, .spiClk, .hostCsN, .hostDin, .hostDout, .hostDoutOe,
      .dataReadyN, .link_role_sel_a(roleSelA), .link_role_sel_b(roleSelB), .cmdOut,
      .cmdValid, .devResetReq, .rdRsp, .rdRspValid, .fwdByte, .fwdValid, .chainByte,
      .chainValid, .rspOverflow, .faultEvent, .faultDataActive, .faultN);

   bmshp_host_model i_host (.spiClk, .hostCsN, .hostDin, .hostDout, .hostDoutOe);

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // Event counters; reads are answered one cycle after decode
   always @(posedge ref_clk) begin
      #1;
      rdRspValid = 1'b0;
      if (cmdValid === 1'b1) begin
         nCmd++;
         lastCmd = cmdOut;
         if (cmdOut.kind === KIND_READ) rdRspValid = 1'b1;
      end
      if (devResetReq === 1'b1) nRst++;
      if (fwdValid === 1'b1) begin
         nFwd++;
         lastFwd = fwdByte;
      end
      if (rspOverflow === 1'b1) nOvf++;
      if (dataReadyN === 1'b1 && prevRdy === 1'b0) nRise++;
      prevRdy = dataReadyN;
   end

   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   task do_reset;
      reset_n = 1'b0;
      tick(8);
      reset_n = 1'b1;
      tick(1);
   endtask : do_reset

   task automatic t_reset;
      `CHK("oe", 1'b0, hostDoutOe)
      `CHK("ready", 1'b1, dataReadyN)
      `CHK("fault", 1'b1, faultN)
      `CHK("valid", 1'b0, cmdValid)
      $display("test reset done");
   endtask : t_reset

   task automatic t_read_write;
      logic [7:0] r1, r2;
      rdRsp = {1'b1, 14'h170a};
      i_host.xfer(8'h11, 8, r1, oeAll);
      i_host.xfer(8'hc0, 8, r1, oeAll);
      `CHK("kind", KIND_READ, lastCmd.kind)
      `CHK("page", 3'h1, lastCmd.page)
      `CHK("addr", 6'h07, lastCmd.addr)
      i_host.xfer(8'h94, 8, r1, oeAll);
      i_host.xfer(8'h0f, 8, r2, oeAll);
      `CHK("reply hi", 8'h17, r1)
      `CHK("reply lo", 8'h0a, r2)
      `CHK("oe frame", 1'b1, oeAll)
      `CHK("oe idle", 1'b0, hostDoutOe)
      i_host.xfer(8'hff, 8, r1, oeAll);
      `CHK("wr kind", KIND_WRITE, lastCmd.kind)
      `CHK("wr data", 14'h0fff, lastCmd.data)
      $display("test read_write done");
   endtask : t_read_write

   task automatic t_commands;
      logic [7:0] r1, r2;
      int n;
      // Miss with nonzero data must still read back as zero
      rdRsp = {1'b0, 14'h3fff};
      i_host.xfer(8'h11, 8, r1, oeAll);
      i_host.xfer(8'hc0, 8, r1, oeAll);
      // Page zero is unmapped: zero reply even with a hit on offer
      rdRsp = {1'b1, 14'h3fff};
      i_host.xfer(8'h01, 8, r1, oeAll);
      i_host.xfer(8'hc0, 8, r2, oeAll);
      `CHK("miss hi", 8'h00, r1)
      `CHK("miss lo", 8'h00, r2)
      i_host.xfer(8'h32, 8, r1, oeAll);
      i_host.xfer(8'h05, 8, r2, oeAll);
      `CHK("bad page hi", 8'h00, r1)
      `CHK("bad page lo", 8'h00, r2)
      `CHK("meas kind", KIND_MEASURE, lastCmd.kind)
      `CHK("meas addr", 6'h08, lastCmd.addr)
      `CHK("meas data", 14'h0005, lastCmd.data)
      n = nRst;
      i_host.xfer(8'h3f, 8, r1, oeAll);
      i_host.xfer(8'h80, 8, r1, oeAll);
      `CHK("act kind", KIND_ACTION, lastCmd.kind)
      `CHK("reset req", n + 1, nRst)
      $display("test commands done");
   endtask : t_commands

   task automatic t_framing;
      logic [7:0] r;
      int n, m;
      n = nCmd;
      m = nRst;
      i_host.xfer(8'h94, 8, r, oeAll);
      i_host.xfer(8'h0f, 4, r, oeAll);
      `CHK("dropped", n, nCmd)
      i_host.xfer(8'h94, 8, r, oeAll);
      i_host.xfer(8'h3f, 8, r, oeAll);
      i_host.xfer(8'h80, 8, r, oeAll);
      `CHK("three bytes", KIND_WRITE, lastCmd.kind)
      `CHK("no reset", m, nRst)
      i_host.xfer(8'h94, 8, r, oeAll);
      `CHK("no wr reply", 8'h00, r)
      // Past the 4000-cycle idle limit
      tick(4100);
      i_host.xfer(8'h3f, 8, r, oeAll);
      i_host.xfer(8'h80, 8, r, oeAll);
      `CHK("timeout", m + 1, nRst)
      $display("test framing done");
   endtask : t_framing

   task automatic t_fault;
      logic [7:0] r;
      faultDataActive = 14'h0001;
      faultEvent = 14'h0001;
      tick(1);
      faultEvent = 14'h0000;
      tick(2);
      `CHK("fault set", 1'b0, faultN)
      for (int k = 0; k < 2; k++) begin
         i_host.xfer(8'hac, 8, r, oeAll);
         i_host.xfer(8'h00, 8, r, oeAll);
         i_host.xfer(8'h00, 8, r, oeAll);
         `CHK("fault clear", k[0], faultN)
         faultDataActive = 14'h0000;
      end
      $display("test fault done");
   endtask : t_fault

   task automatic t_chain;
      logic [7:0] r;
      int n, m;
      roleSelB = 1'b1;
      do_reset();
      tick(6);
      n = nFwd;
      i_host.xfer(8'h11, 8, r, oeAll);
      `CHK("fwd count", n + 1, nFwd)
      `CHK("fwd byte", 8'h11, lastFwd)
      `CHK("no drive", 1'b0, oeAll)
      m = nOvf;
      for (int k = 0; k < 5; k++) begin
         chainByte = 8'ha0 + 8'(k);
         chainValid = 1'b1;
         tick(1);
      end
      chainValid = 1'b0;
      tick(3);
      `CHK("overflow", m + 1, nOvf)
      `CHK("pending", 1'b0, dataReadyN)
      m = nRise;
      for (int k = 0; k < 4; k++) begin
         for (int w = 0; w < 20 && dataReadyN !== 1'b0; w++) tick(1);
         i_host.xfer(8'h5a, 8, r, oeAll);
         `CHK("chain byte", 8'ha0 + 8'(k), r)
         `CHK("chain oe", 1'b1, oeAll)
      end
      tick(4);
      `CHK("releases", m + 4, nRise)
      `CHK("drained", 1'b1, dataReadyN)
      `CHK("ignored", n + 1, nFwd)
      // Role 11 leaves the port inert
      roleSelA = 1'b1;
      tick(4);
      m = nCmd;
      i_host.xfer(8'h11, 8, r, oeAll);
      tick(4);
      `CHK("inert oe", 1'b0, oeAll)
      `CHK("inert fwd", n + 1, nFwd)
      `CHK("inert cmd", m, nCmd)
      $display("test chain done");
   endtask : t_chain

   task end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, failCount);
      if (failCount == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (20000) @(posedge ref_clk);
      failCount++;
      $display("watchdog expired");
      end_sim();
   end

   initial begin
      roleSelA = 1'b0;
      roleSelB = 1'b0;
      rdRsp = '0;
      chainByte = 8'h00;
      chainValid = 1'b0;
      faultEvent = 14'h0000;
      faultDataActive = 14'h0000;
      do_reset();
      t_reset();
      tick(6);
      t_read_write();
      t_commands();
      t_framing();
      t_fault();
      t_chain();
      end_sim();
   end
endmodule : testbench
